// *** include/touch_probe_pkg.sv ***
// constants and carriers for the touch-probe latch and status block
// Notes on behaviour
// R1 - single mode captures first edge; continuous every edge
// R2 - master clears probe 2 enable to change its setup
// R3 - master changes probe 2 setup only while disabled
// R4 - ctrl bit 10: digital input or index source
// R5 - ctrl bits 12/13 enable rising/falling capture
// R6 - status bit 0 shows probe 1 enabled
// R7 - status bit 1: probe 1 rising captured
// R8 - status bit 2: probe 1 falling captured
// R9 - status bit 6 shows probe 1 source
// R10 - status bit 7 shows probe 1 source level
// R11 - status bit 8 shows probe 2 enabled
// R12 - status bit 9: probe 2 rising captured
// R13 - status bit 10: probe 2 falling captured
// R14 - status bit 14 shows probe 2 source
// R15 - status bit 15 shows probe 2 source level
// R16 - capture stores signed 32-bit encoder position
// R17 - re-enable clears flags; reserved bits zero
// R18 - inputs synchronised; one capture per edge
package touch_probe_pkg;

  // object dictionary indexes of the two words and the four latched positions
  localparam logic [15:0] CTRL_INDEX = 16'h60B8;
  localparam logic [15:0] STATUS_INDEX = 16'h60B9;
  localparam logic [15:0] POS_INDEX_P1_RISE = 16'h60BA;
  localparam logic [15:0] POS_INDEX_P1_FALL = 16'h60BB;
  localparam logic [15:0] POS_INDEX_P2_RISE = 16'h60BC;
  localparam logic [15:0] POS_INDEX_P2_FALL = 16'h60BD;

  localparam int NUM_PROBES = 2;
  localparam int PROBE_FIELD_W = 8;
  localparam int POS_W = 32;
  localparam int SYNC_STAGES = 2;

  // per-probe byte positions inside both words
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_CONT_BIT = 1;
  localparam int CTRL_SRC_BIT = 2;
  localparam int CTRL_RISE_BIT = 4;
  localparam int CTRL_FALL_BIT = 5;
  localparam int STAT_ENABLE_BIT = 0;
  localparam int STAT_RISE_BIT = 1;
  localparam int STAT_FALL_BIT = 2;
  localparam int STAT_SRC_BIT = 6;
  localparam int STAT_LEVEL_BIT = 7;

  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic signed [31:0] POS_RESET = 32'sh00000000;

  // one probe's byte of the control word, msb first
  typedef struct packed {
    logic [1:0] rsv_hi;
    logic fall_en;
    logic rise_en;
    logic rsv_mid;
    logic src_index;
    logic continuous;
    logic enable;
  } probe_ctrl_t;

  // one probe's byte of the status word, msb first
  typedef struct packed {
    logic level;
    logic src_index;
    logic [2:0] rsv;
    logic fall_done;
    logic rise_done;
    logic enabled;
  } probe_stat_t;

  typedef struct packed {
    logic signed [31:0] rise_pos;
    logic signed [31:0] fall_pos;
  } probe_latch_t;

endpackage : touch_probe_pkg

// *** rtl/touch_probe_latch_status.sv ***
// touch-probe edge capture, latched positions and probe status word
`timescale 1ns/10ps
`default_nettype none

module touch_probe_latch_status (
  input wire logic core_clk, // drive clock, 200 MHz
  input wire logic sys_rst, // synchronous reset, high
  input wire logic clk_en, // freezes all state while low
  input wire logic [15:0] ctrl_word, // probe control word as written by the master
  input wire logic probe1_digital_input, // probe 1 digital input pin, asynchronous
  input wire logic probe2_digital_input, // probe 2 digital input pin, asynchronous
  input wire logic encoder_index, // encoder index pulse, asynchronous
  input wire logic signed [31:0] encoder_pos, // current encoder position, core_clk domain
  output logic [15:0] status_word, // probe status word
  output touch_probe_pkg::probe_latch_t [1:0] latched_pos // [0] probe 1, [1] probe 2
);

  localparam int NP = touch_probe_pkg::NUM_PROBES;
  localparam int FW = touch_probe_pkg::PROBE_FIELD_W;
  localparam int NS = NP + 1;

  if (NP * FW != 16) begin : g_bad_width
    $error("probe fields must fill the 16-bit words");
  end

  // pins: [0] probe 1 input, [1] probe 2 input, [2] index pulse
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] sync1_r;
  logic [NS-1:0] sync2_r;
  logic [NP-1:0] level_prev_r;
  logic [NP-1:0] enable_prev_r;
  logic [NP-1:0] rise_done_r;
  logic [NP-1:0] fall_done_r;
  logic [15:0] status_r;
  touch_probe_pkg::probe_latch_t [NP-1:0] pos_r;

  logic [NP-1:0] level_now;
  logic [NP-1:0] enable_now;
  logic [NP-1:0] rise_done_nxt;
  logic [NP-1:0] fall_done_nxt;
  logic [15:0] status_nxt;
  touch_probe_pkg::probe_latch_t [NP-1:0] pos_nxt;

  assign pin_raw = {encoder_index, probe2_digital_input, probe1_digital_input};

  for (genvar p = 0; p < NP; p++) begin : g_probe
    touch_probe_pkg::probe_ctrl_t ctl;
    logic level;
    logic rise_seen;
    logic fall_seen;
    logic rearm;
    logic cap_rise;
    logic cap_fall;

    assign ctl = touch_probe_pkg::probe_ctrl_t'(ctrl_word[p*FW +: FW]);
    // source mux on synchronised levels only
    assign level = ctl.src_index ? sync2_r[NS-1] : sync2_r[p]; // see R4 see R18
    assign rise_seen = level & ~level_prev_r[p]; // see R18
    assign fall_seen = ~level & level_prev_r[p]; // see R18
    assign rearm = ctl.enable & ~enable_prev_r[p];
    // single mode: an edge whose flag is already up no longer captures
    assign cap_rise = ctl.enable & ctl.rise_en & rise_seen
                      & (ctl.continuous | ~rise_done_r[p]); // see R1 see R5
    assign cap_fall = ctl.enable & ctl.fall_en & fall_seen
                      & (ctl.continuous | ~fall_done_r[p]); // see R1 see R5
    // capture beats the re-enable clear in the same cycle
    assign rise_done_nxt[p] = cap_rise | (rise_done_r[p] & ~rearm); // see R17
    assign fall_done_nxt[p] = cap_fall | (fall_done_r[p] & ~rearm); // see R17
    assign pos_nxt[p].rise_pos = cap_rise ? encoder_pos : pos_r[p].rise_pos; // see R16
    assign pos_nxt[p].fall_pos = cap_fall ? encoder_pos : pos_r[p].fall_pos; // see R16
    assign level_now[p] = level;
    assign enable_now[p] = ctl.enable;
    // enable, flags, source and live level; reserved bits forced low
    assign status_nxt[p*FW +: FW] = touch_probe_pkg::probe_stat_t'{
      level: level, // see R10 see R15
      src_index: ctl.src_index, // see R9 see R14
      rsv: 3'h0, // see R17
      fall_done: fall_done_nxt[p], // see R8 see R13
      rise_done: rise_done_nxt[p], // see R7 see R12
      enabled: ctl.enable // see R6 see R11
    };
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else if (clk_en) begin
      sync1_r <= pin_raw; // see R18
      sync2_r <= sync1_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      level_prev_r <= '0;
      enable_prev_r <= '0;
      rise_done_r <= '0;
      fall_done_r <= '0;
    end else if (clk_en) begin
      level_prev_r <= level_now;
      enable_prev_r <= enable_now;
      rise_done_r <= rise_done_nxt;
      fall_done_r <= fall_done_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      status_r <= touch_probe_pkg::STATUS_RESET;
      pos_r <= {NP{touch_probe_pkg::POS_RESET, touch_probe_pkg::POS_RESET}};
    end else if (clk_en) begin
      status_r <= status_nxt;
      pos_r <= pos_nxt;
    end
  end

  assign status_word = status_r;
  assign latched_pos = pos_r;

endmodule : touch_probe_latch_status

`default_nettype wire

// *** sim/touch_probe_latch_status_sva.sv ***
// checker for the touch probe block
`timescale 1ns/10ps
`default_nettype none
module touch_probe_latch_status_sva (
  input wire logic core_clk, // clock
  input wire logic sys_rst, // reset
  input wire logic clk_en, // enable
  input wire logic [15:0] ctrl_word, // control
  input wire logic probe2_digital_input, // pin
  input wire logic signed [31:0] encoder_pos, // position
  input wire logic [15:0] status_word, // status
  input wire touch_probe_pkg::probe_latch_t [1:0] latched_pos // latches
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire [15:0] c = ctrl_word;
  wire [15:0] s = status_word;
  wire p = probe2_digital_input;
  wire on = c[8] && !c[10] && clk_en;
  sequence up; clk_en ##1 !p && clk_en ##1 p; endsequence
  sequence dn; clk_en ##1 p && clk_en ##1 !p; endsequence
  rsv_zero_a: assert property (s[5:3] == 3'h0 && s[13:11] == 3'h0)
    else $error("reserved bit set");
  p1_state_a: assert property (!$past(sys_rst) && $past(clk_en) |->
    s[0] == $past(c[0]) && s[6] == $past(c[2])) else $error("p1 state");
  p2_state_a: assert property (!$past(sys_rst) && $past(clk_en) |->
    s[8] == $past(c[8]) && s[14] == $past(c[10])) else $error("p2 state");
  p2_rise_a: assert property (up ##0 (on && c[12] && (c[9] || !s[9]))[*3] |=> s[9] &&
    latched_pos[1].rise_pos == $past(encoder_pos)) else $error("rise missed");
  p2_fall_a: assert property (dn ##0 (on && c[13] && (c[9] || !s[10]))[*3] |=> s[10] &&
    latched_pos[1].fall_pos == $past(encoder_pos)) else $error("fall missed");
  one_shot_a: assert property (s[9] && c[8] && !c[9] && $past(c[8]) |=>
    $stable(latched_pos[1].rise_pos)) else $error("second capture");
  flag_clear_a: assert property (!$past(sys_rst) ##0 (clk_en && $stable(p))[*3] ##0 !c[8]
    ##1 on |=> s[10:9] == 2'h0) else $error("flags kept");
  p2_level_a: assert property ((!c[10] && clk_en && $stable(p))[*4] |-> s[15] == p)
    else $error("level wrong");
endmodule : touch_probe_latch_status_sva
bind touch_probe_latch_status touch_probe_latch_status_sva u_touch_probe_latch_status_sva (.*);
`default_nettype wire

// *** sim/probe_master.sv ***
// fieldbus master model writing the control word
`timescale 1ns/10ps
`default_nettype none
module probe_master (
  input wire logic core_clk, // clock
  output logic [15:0] ctrl_word // control word
);
  initial ctrl_word = 16'h0000;
  // probe 2 setup is frozen while enabled
  task automatic put(input logic [15:0] w);
    @(negedge core_clk);
    ctrl_word = ctrl_word[8] && w[8] ? {ctrl_word[15:9], w[8:0]} : w;
  endtask : put
endmodule : probe_master
`default_nettype wire

// *** sim/touch_probe_latch_status_bench.sv ***
// bench for the touch probe block
`timescale 1ns/10ps
`default_nettype none
module touch_probe_latch_status_bench;
  logic core_clk = 1'b0, sys_rst = 1'b1, pin2 = 1'b0, idx = 1'b0, pin1 = 1'b0, ce = 1'b1;
  logic signed [31:0] enc = 32'sh00000000, e1, e2;
  logic [15:0] cw, st;
  touch_probe_pkg::probe_latch_t [1:0] lat;
  int failures = 0, n_tests = 0;
  probe_master u_probe_master (.core_clk(core_clk), .ctrl_word(cw));
  touch_probe_latch_status u_touch_probe_latch_status (.core_clk(core_clk), .sys_rst(sys_rst),
    .clk_en(ce), .ctrl_word(cw), .probe1_digital_input(pin1), .probe2_digital_input(pin2),
    .encoder_index(idx), .encoder_pos(enc), .status_word(st), .latched_pos(lat));
  initial forever #2.5 core_clk = ~core_clk;
  always @(negedge core_clk) enc <= enc - 32'sh00000007;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) $display("mismatch %0t %h %h", $time, got, exp);
    failures += int'(got !== exp);
  endtask : chk
  task automatic test_done;
    $display("%0d of %0d failed", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  // position seen two edges after the pin moves
  task automatic hit(ref logic pin, input logic v, output logic signed [31:0] e);
    @(negedge core_clk) pin = v;
    repeat (2) @(negedge core_clk);
    #1 e = enc;
    @(negedge core_clk);
  endtask : hit
  task automatic t_single;
    u_probe_master.put(16'h1000);
    u_probe_master.put(16'h1100);
    hit(pin2, 1'b1, e2);
    chk(st, 16'h8300);
    hit(pin2, 1'b0, e1);
    hit(pin2, 1'b1, e1);
    chk(lat[1].rise_pos, e2);
  endtask : t_single
  task automatic t_cont;
    u_probe_master.put(16'h0000);
    u_probe_master.put(16'h3200);
    u_probe_master.put(16'h3300);
    hit(pin2, 1'b0, e1);
    chk(st, 16'h0500);
    hit(pin2, 1'b1, e2);
    hit(pin2, 1'b0, e1);
    chk(lat[1].fall_pos, e1);
  endtask : t_cont
  task automatic t_index;
    u_probe_master.put(16'h0414);
    u_probe_master.put(16'h0415);
    hit(idx, 1'b1, e1);
    chk(st, 16'hC6C3);
    chk(lat[0].rise_pos, e1);
  endtask : t_index
  // probe 1 on its digital input, then a frozen stretch with clk_en low
  task automatic t_probe1;
    u_probe_master.put(16'h0000);
    u_probe_master.put(16'h0020);
    u_probe_master.put(16'h0021);
    hit(pin1, 1'b1, e1);
    chk(st, 16'h0681);
    hit(pin1, 1'b0, e1);
    chk(st, 16'h0605);
    chk(lat[0].fall_pos, e1);
    @(negedge core_clk) ce = 1'b0;
    pin1 = 1'b1;
    repeat (4) @(negedge core_clk);
    chk(st, 16'h0605);
    ce = 1'b1;
    repeat (3) @(negedge core_clk);
    chk(st, 16'h0685);
    chk(lat[0].fall_pos, e1);
  endtask : t_probe1
  initial begin
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge core_clk);
    chk(st, 16'h0000);
    t_single;
    t_cont;
    t_index;
    t_probe1;
    test_done;
  end
  initial begin
    #20000 failures++;
    test_done;
  end
endmodule : touch_probe_latch_status_bench
`default_nettype wire
